// >>> core/rgb_pkg.sv
// Constants for the RGB LED driver register bank: word indexes, fields, resets.
// Assumes an AHB-Lite slave where byte address equals four times the word index.
package rgb_pkg;
  localparam int IDX_W = 7;
  localparam int IDX_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_LED_CTRL = 7'h00;
  localparam logic [IDX_W-1:0] IDX_RED_CUR = 7'h01;
  localparam logic [IDX_W-1:0] IDX_GREEN_CUR = 7'h02;
  localparam logic [IDX_W-1:0] IDX_BLUE_CUR = 7'h03;
  localparam logic [IDX_W-1:0] IDX_BRIGHT = 7'h04;
  localparam logic [IDX_W-1:0] IDX_BOOST = 7'h05;
  localparam logic [IDX_W-1:0] IDX_GEN_CTRL = 7'h06;
  localparam logic [IDX_W-1:0] IDX_ADC_HI = 7'h08;
  localparam logic [IDX_W-1:0] IDX_ADC_LO = 7'h09;
  localparam logic [IDX_W-1:0] IDX_RED_CORR = 7'h0a;
  localparam logic [IDX_W-1:0] IDX_GREEN_CORR = 7'h0b;
  localparam logic [IDX_W-1:0] IDX_BLUE_CORR = 7'h0c;
  localparam logic [IDX_W-1:0] IDX_MEM_CTRL = 7'h0d;
  localparam logic [IDX_W-1:0] WIN_FIRST = 7'h40;
  localparam logic [IDX_W-1:0] WIN_LAST = 7'h5f;
  localparam int WIN_W = 5;
  localparam int PAGE_W = 2;
  localparam int MEM_W = PAGE_W + WIN_W;
  localparam logic [MEM_W-1:0] MEM_RED_CUR = 7'h5f;
  localparam logic [MEM_W-1:0] MEM_GREEN_CUR = 7'h60;
  localparam logic [MEM_W-1:0] MEM_BLUE_CUR = 7'h61;
  localparam logic [7:0] RST_LED_CTRL = 8'h10;
  localparam logic [7:0] RST_CUR = 8'h55;
  localparam logic [7:0] RST_CORR = 8'h80;
  localparam logic [7:0] RST_GEN_CTRL = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_BRIGHT = 8'h0f;
  localparam logic [7:0] MASK_BOOST = 8'h1f;
  localparam logic [7:0] MASK_GEN_CTRL = 8'h3f;
  localparam logic [7:0] MASK_MEM_CTRL = 8'h73;
  localparam int BIT_EN_R = 0;
  localparam int BIT_EN_G = 1;
  localparam int BIT_EN_B = 2;
  localparam int BIT_AUTO = 3;
  localparam int BIT_FAST = 4;
  localparam int BIT_FADE = 5;
  localparam int SEQ_LSB = 6;
  localparam int BIT_VOUT_AUTO = 2;
  localparam int BIT_TEMP_SRC = 5;
  localparam int PAGE_LSB = 0;
  localparam int BIT_RELOAD = 4;
  localparam int BIT_PROGRAM = 5;
  localparam int BIT_ERASE = 6;
  localparam int BIT_READY = 7;
  localparam int ADC_W = 12;
  localparam int ADC_HI_LSB = 8;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_RD_LOAD = 4'b0100,
    ST_RD_DONE = 4'b1000
  } rgb_state_type;
endpackage

// >>> core/rgb_cal_if.sv
// Link between the register bank and the calibration memory array.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface rgb_cal_if;
  logic wr_en;
  logic [1:0] page;
  logic [4:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] red_code;
  logic [7:0] green_code;
  logic [7:0] blue_code;
  modport bank (output wr_en, page, idx, wdata, input rdata, red_code, green_code, blue_code);
  modport mem (input wr_en, page, idx, wdata, output rdata, red_code, green_code, blue_code);
endinterface
`default_nettype wire

// >>> core/rgb_cal_mem.sv
// Calibration working memory: four pages of 32 bytes with a paged window port.
// Assumes the bank drives page, index and write data in the write's data phase.
`timescale 1ns/1ps
`default_nettype none
module rgb_cal_mem
  import rgb_pkg::*;
(
  input wire logic i_clk, // System clock.
  rgb_cal_if.mem cal // Window port and stored current codes.
);
  logic [7:0] mem [0:(1<<MEM_W)-1];
  logic [MEM_W-1:0] addr;

  // The array has no reset: it is working memory written only through the window port.
  assign addr = {cal.page, cal.idx};
  always_ff @(posedge i_clk) begin
    if (cal.wr_en) begin
      mem[addr] <= cal.wdata;
    end
  end
  assign cal.rdata = mem[addr];
  assign cal.red_code = mem[MEM_RED_CUR];
  assign cal.green_code = mem[MEM_GREEN_CUR];
  assign cal.blue_code = mem[MEM_BLUE_CUR];

  a_mem_write_lands: assert property (
    @(posedge i_clk) cal.wr_en |=> mem[$past(addr)] == $past(cal.wdata))
    else $error("Window write did not reach the selected page.");
endmodule
`default_nettype wire

// >>> core/rgb_reg_bank.sv
// Register bank of the RGB LED driver, reached as an AHB-Lite slave.
// Assumes ADC result and memory ready come from logic on I_CLK_SYS.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rgb_reg_bank
  import rgb_pkg::*;
(
  input wire logic I_CLK_SYS, // System clock, 250 MHz.
  input wire logic I_RST, // Synchronous reset, active high.
  input wire logic I_HSEL, // Slave select.
  input wire logic [31:0] I_HADDR, // Byte address.
  input wire logic [1:0] I_HTRANS, // Transfer type.
  input wire logic I_HWRITE, // Write when high.
  input wire logic [2:0] I_HSIZE, // Transfer size.
  input wire logic [31:0] I_HWDATA, // Write data.
  input wire logic I_HREADY, // Bus ready.
  output logic O_HREADYOUT, // Slave ready.
  output logic O_HRESP, // Always OKAY.
  output logic [31:0] O_HRDATA, // Read data.
  input wire logic [11:0] I_ADC_RESULT, // Latest ADC conversion.
  input wire logic I_MEMORY_READY, // Memory controller idle.
  output logic [2:0] O_LED_EN, // Blue, green, red output enables.
  output logic [1:0] O_SEQ_MODE, // PWM sequencing mode.
  output logic O_SEQUENTIAL, // High in any sequential mode.
  output logic O_FADE_EN, // Automatic fade enable.
  output logic O_PWM_FAST, // High PWM frequency select.
  output logic O_AUTO_COMP, // Automatic compensation enable.
  output logic [7:0] O_RED_CURRENT_CODE, // Effective red current code.
  output logic [7:0] O_GREEN_CURRENT_CODE, // Effective green current code.
  output logic [7:0] O_BLUE_CURRENT_CODE, // Effective blue current code.
  output logic [7:0] O_RED_CORRECTION, // Red brightness multiplier.
  output logic [7:0] O_GREEN_CORRECTION, // Green brightness multiplier.
  output logic [7:0] O_BLUE_CORRECTION, // Blue brightness multiplier.
  output logic [7:0] O_BRIGHTNESS, // Brightness select register.
  output logic [7:0] O_BOOST_VOLTAGE, // Boost voltage select register.
  output logic [7:0] O_GENERAL_CONTROL, // General control register.
  output logic O_TEMPERATURE_SOURCE_SELECT, // Temperature sensing source.
  output logic [1:0] O_MEMORY_PAGE_SELECT, // Mirrored page.
  output logic O_MEMORY_ERASE_TRIGGER, // Erase command bit.
  output logic O_MEMORY_PROGRAM_TRIGGER, // Program command bit.
  output logic O_MEMORY_RELOAD_TRIGGER // Reload command bit.
);
  rgb_cal_if cal ();
  rgb_state_type state, next_state;
  logic [IDX_W-1:0] addr_idx, next_addr_idx;
  logic addr_ok, next_addr_ok;
  logic [31:0] hrdata, next_hrdata;
  logic [7:0] led_ctrl, next_led_ctrl;
  logic [7:0] red_cur, next_red_cur;
  logic [7:0] green_cur, next_green_cur;
  logic [7:0] blue_cur, next_blue_cur;
  logic [7:0] bright, next_bright;
  logic [7:0] boost, next_boost;
  logic [7:0] gen_ctrl, next_gen_ctrl;
  logic [7:0] red_corr, next_red_corr;
  logic [7:0] green_corr, next_green_corr;
  logic [7:0] blue_corr, next_blue_corr;
  logic [7:0] mem_ctrl, next_mem_ctrl;
  logic [7:0] red_out, next_red_out;
  logic [7:0] green_out, next_green_out;
  logic [7:0] blue_out, next_blue_out;
  logic accept;
  logic in_window;
  logic wr_cycle;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [7:0] mem_ctrl_view;
  logic [PAGE_W-1:0] wr_page;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  rgb_cal_mem u_mem (
    .i_clk(I_CLK_SYS),
    .cal(cal.mem)
  );

  // Bus front end. Writes finish with no wait state; reads take one, so
  // that read data always comes from a flop and sees any write just before.
  assign accept = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign in_window = (addr_idx >= WIN_FIRST) && (addr_idx <= WIN_LAST);
  assign wr_cycle = (state == ST_WRITE) && addr_ok;
  assign wr_byte = I_HWDATA[7:0];
  assign wr_page = wr_byte[PAGE_LSB +: PAGE_W];

  always_comb begin
    next_state = ST_IDLE;
    next_addr_idx = addr_idx;
    next_addr_ok = addr_ok;
    next_hrdata = hrdata;
    if (accept) begin
      next_state = I_HWRITE ? ST_WRITE : ST_RD_LOAD;
      next_addr_idx = I_HADDR[IDX_LSB +: IDX_W];
      // Only word-aligned addresses inside the map with a size up to a word hit.
      next_addr_ok = (I_HADDR[IDX_LSB-1:0] == '0) && (I_HADDR[31:IDX_LSB+IDX_W] == '0)
                     && (I_HSIZE <= SIZE_WORD);
    end else if (state == ST_RD_LOAD) begin
      next_state = ST_RD_DONE;
    end
    if (state == ST_RD_LOAD) begin
      next_hrdata = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      state <= ST_IDLE;
      addr_idx <= '0;
      addr_ok <= 1'b0;
      hrdata <= '0;
    end else begin
      state <= next_state;
      addr_idx <= next_addr_idx;
      addr_ok <= next_addr_ok;
      hrdata <= next_hrdata;
    end
  end

  assign O_HREADYOUT = (state != ST_RD_LOAD);
  assign O_HRESP = HRESP_OKAY;
  assign O_HRDATA = hrdata;

  // The ready flag is live state, never the stored bit.
  always_comb begin
    mem_ctrl_view = mem_ctrl;
    mem_ctrl_view[BIT_READY] = I_MEMORY_READY;
  end

  always_comb begin
    rd_hit = addr_ok;
    rd_byte = RST_ZERO;
    if (addr_ok && in_window) begin
      rd_byte = cal.rdata;
    end else if (addr_ok) begin
      case (addr_idx)
        IDX_LED_CTRL: rd_byte = led_ctrl;
        IDX_RED_CUR: rd_byte = red_cur;
        IDX_GREEN_CUR: rd_byte = green_cur;
        IDX_BLUE_CUR: rd_byte = blue_cur;
        IDX_BRIGHT: rd_byte = bright;
        IDX_BOOST: rd_byte = boost;
        IDX_GEN_CTRL: rd_byte = gen_ctrl;
        IDX_ADC_HI: rd_byte = 8'(I_ADC_RESULT >> ADC_HI_LSB);
        IDX_ADC_LO: rd_byte = 8'(I_ADC_RESULT);
        IDX_RED_CORR: rd_byte = red_corr;
        IDX_GREEN_CORR: rd_byte = green_corr;
        IDX_BLUE_CORR: rd_byte = blue_corr;
        IDX_MEM_CTRL: rd_byte = mem_ctrl_view;
        default: begin
          rd_hit = 1'b0;
          rd_byte = RST_ZERO;
        end
      endcase
    end
  end

  // Register writes. Masks keep unused and read-only bits at zero.
  always_comb begin
    next_led_ctrl = led_ctrl;
    next_red_cur = red_cur;
    next_green_cur = green_cur;
    next_blue_cur = blue_cur;
    next_bright = bright;
    next_boost = boost;
    next_gen_ctrl = gen_ctrl;
    next_red_corr = red_corr;
    next_green_corr = green_corr;
    next_blue_corr = blue_corr;
    next_mem_ctrl = mem_ctrl;
    if (wr_cycle) begin
      case (addr_idx)
        IDX_LED_CTRL: next_led_ctrl = merge(led_ctrl, wr_byte, MASK_FULL);
        IDX_RED_CUR: next_red_cur = merge(red_cur, wr_byte, MASK_FULL);
        IDX_GREEN_CUR: next_green_cur = merge(green_cur, wr_byte, MASK_FULL);
        IDX_BLUE_CUR: next_blue_cur = merge(blue_cur, wr_byte, MASK_FULL);
        IDX_BRIGHT: next_bright = merge(bright, wr_byte, MASK_BRIGHT);
        IDX_BOOST: next_boost = merge(boost, wr_byte, MASK_BOOST);
        IDX_GEN_CTRL: next_gen_ctrl = merge(gen_ctrl, wr_byte, MASK_GEN_CTRL);
        IDX_RED_CORR: next_red_corr = merge(red_corr, wr_byte, MASK_FULL);
        IDX_GREEN_CORR: next_green_corr = merge(green_corr, wr_byte, MASK_FULL);
        IDX_BLUE_CORR: next_blue_corr = merge(blue_corr, wr_byte, MASK_FULL);
        IDX_MEM_CTRL: begin
          next_mem_ctrl = merge(mem_ctrl, wr_byte, MASK_MEM_CTRL);
          // Erase and program may not be asked together; such a write keeps both as they were.
          if (wr_byte[BIT_ERASE] && wr_byte[BIT_PROGRAM]) begin
            next_mem_ctrl[BIT_ERASE] = mem_ctrl[BIT_ERASE];
            next_mem_ctrl[BIT_PROGRAM] = mem_ctrl[BIT_PROGRAM];
          end
        end
        default: begin
          next_mem_ctrl = mem_ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      led_ctrl <= RST_LED_CTRL;
      red_cur <= RST_CUR;
      green_cur <= RST_CUR;
      blue_cur <= RST_CUR;
      bright <= RST_ZERO;
      boost <= RST_ZERO;
      gen_ctrl <= RST_GEN_CTRL;
      red_corr <= RST_CORR;
      green_corr <= RST_CORR;
      blue_corr <= RST_CORR;
      mem_ctrl <= RST_ZERO;
    end else begin
      led_ctrl <= next_led_ctrl;
      red_cur <= next_red_cur;
      green_cur <= next_green_cur;
      blue_cur <= next_blue_cur;
      bright <= next_bright;
      boost <= next_boost;
      gen_ctrl <= next_gen_ctrl;
      red_corr <= next_red_corr;
      green_corr <= next_green_corr;
      blue_corr <= next_blue_corr;
      mem_ctrl <= next_mem_ctrl;
    end
  end

  // Calibration window, mirrored through the selected page.
  assign cal.wr_en = wr_cycle && in_window;
  assign cal.page = mem_ctrl[PAGE_LSB +: PAGE_W];
  assign cal.idx = addr_idx[WIN_W-1:0];
  assign cal.wdata = wr_byte;

  // Effective current codes. In automatic mode the stored codes are used;
  // software keeps that mode off while rewriting memory, so a half-written
  // page never reaches the sinks.
  always_comb begin
    next_red_out = red_cur;
    next_green_out = green_cur;
    next_blue_out = blue_cur;
    if (led_ctrl[BIT_AUTO]) begin
      next_red_out = cal.red_code;
      next_green_out = cal.green_code;
      next_blue_out = cal.blue_code;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      red_out <= RST_CUR;
      green_out <= RST_CUR;
      blue_out <= RST_CUR;
    end else begin
      red_out <= next_red_out;
      green_out <= next_green_out;
      blue_out <= next_blue_out;
    end
  end

  assign O_LED_EN = {led_ctrl[BIT_EN_B], led_ctrl[BIT_EN_G], led_ctrl[BIT_EN_R]};
  assign O_SEQ_MODE = led_ctrl[SEQ_LSB +: 2];
  assign O_SEQUENTIAL = (led_ctrl[SEQ_LSB +: 2] != 2'h0);
  assign O_FADE_EN = led_ctrl[BIT_FADE];
  assign O_PWM_FAST = led_ctrl[BIT_FAST];
  assign O_AUTO_COMP = led_ctrl[BIT_AUTO];
  assign O_RED_CURRENT_CODE = red_out;
  assign O_GREEN_CURRENT_CODE = green_out;
  assign O_BLUE_CURRENT_CODE = blue_out;
  assign O_RED_CORRECTION = red_corr;
  assign O_GREEN_CORRECTION = green_corr;
  assign O_BLUE_CORRECTION = blue_corr;
  assign O_BRIGHTNESS = bright;
  assign O_BOOST_VOLTAGE = boost;
  assign O_GENERAL_CONTROL = gen_ctrl;
  assign O_TEMPERATURE_SOURCE_SELECT = gen_ctrl[BIT_TEMP_SRC];
  assign O_MEMORY_PAGE_SELECT = mem_ctrl[PAGE_LSB +: PAGE_W];
  assign O_MEMORY_ERASE_TRIGGER = mem_ctrl[BIT_ERASE];
  assign O_MEMORY_PROGRAM_TRIGGER = mem_ctrl[BIT_PROGRAM];
  assign O_MEMORY_RELOAD_TRIGGER = mem_ctrl[BIT_RELOAD];

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  sequence s_read_accept;
    accept && !I_HWRITE;
  endsequence
  sequence s_read_answer;
    !O_HREADYOUT ##1 O_HREADYOUT;
  endsequence
  sequence s_write_to(logic [IDX_W-1:0] idx);
    wr_cycle && addr_idx == idx;
  endsequence

  a_read_wait_state: assert property (s_read_accept |=> s_read_answer)
    else $error("Read did not answer after one wait state.");
  a_reset_fast_adaptive: assert property (
    $past(I_RST) |-> O_PWM_FAST && O_GENERAL_CONTROL[BIT_VOUT_AUTO]
                     && led_ctrl == RST_LED_CTRL && gen_ctrl == RST_GEN_CTRL)
    else $error("Fast PWM or adaptive voltage not set after reset.");
  a_reset_correction: assert property (
    $past(I_RST) |-> O_RED_CORRECTION == RST_CORR && O_GREEN_CORRECTION == RST_CORR
                     && O_BLUE_CORRECTION == RST_CORR)
    else $error("Correction registers not at unity after reset.");
  a_reset_current: assert property (
    $past(I_RST) |-> red_cur == RST_CUR && green_cur == RST_CUR && blue_cur == RST_CUR)
    else $error("Current set registers not at default after reset.");
  a_reset_zero: assert property (
    $past(I_RST) |-> bright == RST_ZERO && boost == RST_ZERO && mem_ctrl == RST_ZERO)
    else $error("Registers without a stated default not cleared.");
  a_auto_source: assert property (
    led_ctrl[BIT_AUTO] |=> O_RED_CURRENT_CODE == $past(cal.red_code)
                           && O_BLUE_CURRENT_CODE == $past(cal.blue_code))
    else $error("Automatic mode did not use stored currents.");
  a_manual_source: assert property (
    !led_ctrl[BIT_AUTO] |=> O_GREEN_CURRENT_CODE == $past(green_cur))
    else $error("Manual mode did not use current set register.");
  a_green_layout: assert property (s_write_to(IDX_GREEN_CUR) |=> green_cur == $past(wr_byte))
    else $error("Green current write not stored as full byte.");
  a_control_write: assert property (
    s_write_to(IDX_LED_CTRL) |=> {O_SEQ_MODE, O_FADE_EN, O_PWM_FAST, O_AUTO_COMP,
                                  O_LED_EN} == $past(wr_byte))
    else $error("LED control fields do not follow the written byte.");
  a_page_select: assert property (
    s_write_to(IDX_MEM_CTRL) |=> O_MEMORY_PAGE_SELECT == $past(wr_page))
    else $error("Page select does not follow the written field.");
  a_window_read: assert property (
    state == ST_RD_LOAD && addr_ok && in_window |=> O_HRDATA == {24'h000000, $past(cal.rdata)})
    else $error("Window read did not return the page byte.");
  a_ready_live: assert property (
    state == ST_RD_LOAD && addr_ok && addr_idx == IDX_MEM_CTRL
    |=> O_HRDATA[BIT_READY] == $past(I_MEMORY_READY))
    else $error("Ready flag does not show live state.");
  a_unmapped_zero: assert property (
    state == ST_RD_LOAD && !rd_hit |=> O_HRDATA == 32'h00000000)
    else $error("Unmapped read returned nonzero data.");
  a_reset_code_out: assert property (
    $past(I_RST) |-> O_RED_CURRENT_CODE == RST_CUR && O_GREEN_CURRENT_CODE == RST_CUR
                     && O_BLUE_CURRENT_CODE == RST_CUR)
    else $error("Effective current codes not at default after reset.");

  // The ADC bytes are read live, not latched, so software must read both
  // halves while the conversion result is steady.
  a_adc_low_live: assert property (
    state == ST_RD_LOAD && addr_ok && addr_idx == IDX_ADC_LO
    |=> O_HRDATA == {24'h000000, $past(I_ADC_RESULT[ADC_HI_LSB-1:0])})
    else $error("ADC low byte does not show the live result.");
  a_adc_high_live: assert property (
    state == ST_RD_LOAD && addr_ok && addr_idx == IDX_ADC_HI
    |=> O_HRDATA == {28'h0000000, $past(I_ADC_RESULT[ADC_W-1:ADC_HI_LSB])})
    else $error("ADC high byte does not show the live result.");

  // Erase and program are exclusive commands; a write naming both changes neither.
  a_erase_program_hold: assert property (
    wr_cycle && addr_idx == IDX_MEM_CTRL && wr_byte[BIT_ERASE] && wr_byte[BIT_PROGRAM]
    |=> $stable(O_MEMORY_ERASE_TRIGGER) && $stable(O_MEMORY_PROGRAM_TRIGGER))
    else $error("Erase and program were both taken from one write.");
endmodule
`default_nettype wire

// >>> dv/rgb_led_driver_register_bank_bench.sv
// Self-checking bench for the RGB LED driver register bank, driven as an AHB-Lite master.
// Assumes a single slave whose ready output is fed back as the bus ready.
`timescale 1ns/1ps
`default_nettype none
module rgb_led_driver_register_bank_bench
  import rgb_pkg::*;
();
  localparam logic [6:0] DEF_IDX [13] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06,
    7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d};
  localparam logic [7:0] DEF_VAL [13] = '{8'h10, 8'h55, 8'h55, 8'h55, 8'h00, 8'h00, 8'h04,
    8'h0a, 8'hbc, 8'h80, 8'h80, 8'h80, 8'h80};
  localparam logic [6:0] RW_IDX [9] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h0a,
    7'h0b, 7'h0c};
  localparam logic [7:0] RW_VAL [9] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'h1f, 8'h3f, 8'hff,
    8'hff, 8'hff};
  localparam logic [6:0] BAD_IDX [5] = '{7'h07, 7'h0e, 7'h3f, 7'h60, 7'h7f};
  localparam logic [7:0] LED_PAT [4] = '{8'h15, 8'h62, 8'ha7, 8'hd0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = SIZE_WORD;
  logic [31:0] hwdata = '0;
  logic [11:0] adc = 12'habc;
  logic mem_ready = 1'b1;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [2:0] led_en;
  wire logic [1:0] seq_mode;
  wire logic seq_on, fade, fast, auto_comp, temp_src, erase, prog_trig, reload;
  wire logic [7:0] cur_r, cur_g, cur_b, corr_r, corr_g, corr_b, bright, boost, gen;
  wire logic [1:0] page;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  rgb_reg_bank u_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata),
    .I_ADC_RESULT(adc), .I_MEMORY_READY(mem_ready), .O_LED_EN(led_en), .O_SEQ_MODE(seq_mode),
    .O_SEQUENTIAL(seq_on), .O_FADE_EN(fade), .O_PWM_FAST(fast), .O_AUTO_COMP(auto_comp),
    .O_RED_CURRENT_CODE(cur_r), .O_GREEN_CURRENT_CODE(cur_g), .O_BLUE_CURRENT_CODE(cur_b),
    .O_RED_CORRECTION(corr_r), .O_GREEN_CORRECTION(corr_g), .O_BLUE_CORRECTION(corr_b),
    .O_BRIGHTNESS(bright), .O_BOOST_VOLTAGE(boost), .O_GENERAL_CONTROL(gen),
    .O_TEMPERATURE_SOURCE_SELECT(temp_src), .O_MEMORY_PAGE_SELECT(page),
    .O_MEMORY_ERASE_TRIGGER(erase), .O_MEMORY_PROGRAM_TRIGGER(prog_trig),
    .O_MEMORY_RELOAD_TRIGGER(reload));

  always #2 clk = ~clk;

  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang in the bus handshake ends the run here instead of stalling forever.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // Ready and read data are sampled half a cycle early, where they already hold
  // the value that the next rising edge will see.
  task automatic wait_ready(output logic [31:0] data);
    logic ready;
    ready = 1'b0;
    data = '0;
    while (ready !== 1'b1) begin
      @(negedge clk);
      ready = hready;
      data = hrdata;
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic [6:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {23'h0, idx, 2'b00};
    hwrite <= wr;
    hsize <= SIZE_WORD;
    wait_ready(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready(rd);
    check("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] val);
    logic [31:0] d;
    bus(idx, 1'b1, val, d);
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [7:0] exp, input string name);
    logic [31:0] d;
    bus(idx, 1'b0, 8'h00, d);
    check(name, {24'h0, exp}, d);
  endtask

  task automatic cur_chk(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    @(posedge clk);
    @(negedge clk);
    check("red_code", 32'(r), 32'(cur_r));
    check("green_code", 32'(g), 32'(cur_g));
    check("blue_code", 32'(b), 32'(cur_b));
    @(posedge clk);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic check_defaults();
    adc <= 12'habc;
    mem_ready <= 1'b1;
    @(negedge clk);
    check("pwm_fast", 32'h1, 32'(fast));
    check("red_code_out", 32'h55, 32'(cur_r));
    check("gen_out", 32'h04, 32'(gen));
    @(posedge clk);
    foreach (DEF_IDX[i]) begin
      rdc(DEF_IDX[i], DEF_VAL[i], "default");
    end
    $display("Test defaults finished");
  endtask

  initial begin
    do_reset();
    check_defaults();
    foreach (RW_IDX[i]) begin
      wr(RW_IDX[i], 8'hff);
      rdc(RW_IDX[i], RW_VAL[i], "masked_rw");
    end
    @(negedge clk);
    check("bright_out", 32'h0f, 32'(bright));
    check("boost_out", 32'h1f, 32'(boost));
    check("temp_src", 32'h1, 32'(temp_src));
    check("corr_out", 32'h00ffffff, {8'h0, corr_r, corr_g, corr_b});
    @(posedge clk);
    foreach (BAD_IDX[i]) begin
      wr(BAD_IDX[i], 8'hff);
      rdc(BAD_IDX[i], 8'h00, "unmapped");
    end
    wr(IDX_ADC_HI, 8'hff);
    wr(IDX_ADC_LO, 8'h00);
    adc <= 12'h5a3;
    mem_ready <= 1'b0;
    rdc(IDX_ADC_HI, 8'h05, "adc_hi");
    rdc(IDX_ADC_LO, 8'ha3, "adc_lo");
    // Erase and program asked for together are dropped; reload and page still land.
    wr(IDX_MEM_CTRL, 8'hff);
    rdc(IDX_MEM_CTRL, 8'h13, "mem_ctrl");
    check("mem_outs", 32'h1, {29'h0, erase, prog_trig, reload});
    wr(IDX_MEM_CTRL, 8'h60);
    wr(IDX_MEM_CTRL, 8'h40);
    rdc(IDX_MEM_CTRL, 8'h40, "mem_erase");
    $display("Test access kinds finished");
    foreach (LED_PAT[i]) begin
      wr(IDX_LED_CTRL, LED_PAT[i]);
      @(negedge clk);
      check("led_en", 32'(LED_PAT[i][2:0]), 32'(led_en));
      check("pwm_fast", 32'(LED_PAT[i][4]), 32'(fast));
      check("fade", 32'(LED_PAT[i][5]), 32'(fade));
      check("seq_mode", 32'(LED_PAT[i][7:6]), 32'(seq_mode));
      check("sequential", 32'(LED_PAT[i][7:6] != 2'b00), 32'(seq_on));
      check("auto", 32'h0, 32'(auto_comp));
      @(posedge clk);
      rdc(IDX_LED_CTRL, LED_PAT[i], "led_ctrl");
    end
    $display("Test LED control finished");
    wr(IDX_LED_CTRL, 8'h00);
    wr(IDX_RED_CUR, 8'h11);
    wr(IDX_GREEN_CUR, 8'h22);
    wr(IDX_BLUE_CUR, 8'h33);
    wr(IDX_MEM_CTRL, 8'h02);
    wr(7'h5f, 8'ha1);
    wr(IDX_MEM_CTRL, 8'h03);
    wr(7'h40, 8'hb2);
    wr(7'h41, 8'hb3);
    wr(IDX_MEM_CTRL, 8'h00);
    wr(7'h40, 8'h5c);
    rdc(7'h40, 8'h5c, "page0");
    wr(IDX_MEM_CTRL, 8'h03);
    @(negedge clk);
    check("page_out", 32'h3, 32'(page));
    @(posedge clk);
    rdc(7'h40, 8'hb2, "page3");
    rdc(7'h41, 8'hb3, "page3");
    wr(IDX_MEM_CTRL, 8'h02);
    rdc(7'h5f, 8'ha1, "page2");
    cur_chk(8'h11, 8'h22, 8'h33);
    wr(IDX_LED_CTRL, 8'h08);
    cur_chk(8'ha1, 8'hb2, 8'hb3);
    check("auto", 32'h1, 32'(auto_comp));
    wr(IDX_LED_CTRL, 8'h00);
    cur_chk(8'h11, 8'h22, 8'h33);
    $display("Test compensation window finished");
    do_reset();
    check_defaults();
    finish_test();
  end
endmodule
`default_nettype wire
